//--- design/tlf_defs.svh
`ifndef TLF_DEFS_SVH
`define TLF_DEFS_SVH

// command codes of the limit and response registers
`define TLF_CMD_OT_WARN 8'h51
`define TLF_CMD_UT_WARN 8'h52
`define TLF_CMD_UT_FAULT 8'h53
`define TLF_CMD_UT_RESP 8'h54

// reset values, linear format: +125, -35, -40 degrees, disable without retry
`define TLF_RST_OT_WARN 16'h007D
`define TLF_RST_UT_WARN 16'h07DD
`define TLF_RST_UT_FAULT 16'h07D8
`define TLF_RST_UT_RESP 8'h80

// response byte field positions
`define TLF_RESP_MODE_LSB 6
`define TLF_RESP_RETRY_LSB 3
`define TLF_RESP_DELAY_LSB 0

// response modes and retry codes
`define TLF_MODE_IGNORE 2'h0
`define TLF_MODE_DELAY 2'h1
`define TLF_MODE_RETRY 2'h2
`define TLF_MODE_LATCH 2'h3
`define TLF_RETRY_NONE 3'h0
`define TLF_RETRY_CONT 3'h7

// linear format: exponent bias that makes the shift non-negative
`define TLF_LIN_FRAC_BITS 16

// delay time unit and clock rate
`define TLF_CLK_MHZ 250
`define TLF_UNIT_TIME_US 1000

`endif

//--- design/tlf_fault_resp.sv
`timescale 1ns/1ns
`include "tlf_defs.svh"

module tlf_fault_resp #(
    parameter int UNIT_CYCLES = `TLF_UNIT_TIME_US * `TLF_CLK_MHZ
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire tlf_pkg::tlf_cmd_t cmd_in,
    input wire logic clear_faults_in,
    input wire logic clear_status_in,
    input wire logic op_on_in,
    input wire logic ctrl_pin_in,
    input wire logic bias_ok_in,
    input wire tlf_pkg::tlf_lin_t temp_in,
    input wire logic temp_valid_in,
    input wire logic other_fault_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic output_en_out,
    output logic ut_fault_out,
    output logic ut_warn_out,
    output logic ot_warn_out,
    output tlf_pkg::tlf_state_t state_out
);

    // number of delay units for a 3-bit code
    function automatic logic [7:0] unit_mult(input logic [2:0] code);
        return 8'h01 << code;
    endfunction : unit_mult

    // attempts allowed for a retry code; continuous is handled apart
    function automatic logic [2:0] retry_limit(input logic [2:0] code);
        return code;
    endfunction : retry_limit

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] ctrl_sync_q;
    logic [1:0] bias_sync_q;
    logic ctrl_s;
    logic bias_s;

    // reset released through two flops
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pin inputs pass two flops; bias reads as lost until seen
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_sync_q <= 2'h0;
            bias_sync_q <= 2'h0;
        end else begin
            ctrl_sync_q <= {ctrl_sync_q[0], ctrl_pin_in};
            bias_sync_q <= {bias_sync_q[0], bias_ok_in};
        end
    end
    assign ctrl_s = ctrl_sync_q[1];
    assign bias_s = bias_sync_q[1];

    tlf_pkg::tlf_lin_t ot_warn_q;
    tlf_pkg::tlf_lin_t ut_warn_q;
    tlf_pkg::tlf_lin_t ut_fault_lim_q;
    tlf_pkg::tlf_resp_t resp_q;

    // command decode
    wire logic hit_ot = cmd_in.code == `TLF_CMD_OT_WARN;
    wire logic hit_utw = cmd_in.code == `TLF_CMD_UT_WARN;
    wire logic hit_utf = cmd_in.code == `TLF_CMD_UT_FAULT;
    wire logic hit_resp = cmd_in.code == `TLF_CMD_UT_RESP;

    // limit and response registers; unmapped codes are ignored
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ot_warn_q <= `TLF_RST_OT_WARN;
            ut_warn_q <= `TLF_RST_UT_WARN;
            ut_fault_lim_q <= `TLF_RST_UT_FAULT;
            resp_q <= `TLF_RST_UT_RESP;
        end else if (cmd_in.wr_en) begin
            if (hit_ot) ot_warn_q <= cmd_in.wdata;
            if (hit_utw) ut_warn_q <= cmd_in.wdata;
            if (hit_utf) ut_fault_lim_q <= cmd_in.wdata;
            if (hit_resp) resp_q <= cmd_in.wdata[7:0];
        end
    end

    // read mux; byte register sits in the low bits, unmapped reads zero
    wire logic [15:0] rd_mux = hit_ot ? ot_warn_q :
                              hit_utw ? ut_warn_q :
                              hit_utf ? ut_fault_lim_q :
                              hit_resp ? {8'h00, resp_q} : 16'h0000;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= cmd_in.rd_en;
            if (cmd_in.rd_en) rd_data_out <= rd_mux;
        end
    end

    // temperature against the three limits
    logic below_fault;
    logic below_warn;
    logic above_warn;

    tlf_lin_cmp u_cmp_fault (
        .a_in(temp_in),
        .b_in(ut_fault_lim_q),
        .a_lt_b_out(below_fault)
    );
    tlf_lin_cmp u_cmp_utw (
        .a_in(temp_in),
        .b_in(ut_warn_q),
        .a_lt_b_out(below_warn)
    );
    tlf_lin_cmp u_cmp_otw (
        .a_in(ot_warn_q),
        .b_in(temp_in),
        .a_lt_b_out(above_warn)
    );

    logic fault_cond_q;
    logic run_q;

    // clear sources; bias loss holds the clear for as long as it lasts
    wire logic run_cmd = ctrl_s & op_on_in & bias_s;
    wire logic run_rise = run_cmd & ~run_q;
    wire logic clr_evt = clear_faults_in | clear_status_in | run_rise | ~bias_s;
    wire logic fault_new = temp_valid_in & below_fault;

    // condition levels follow each reading; flags are only reported
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_cond_q <= 1'b0;
            ut_warn_out <= 1'b0;
            ot_warn_out <= 1'b0;
            run_q <= 1'b0;
        end else begin
            run_q <= run_cmd;
            if (temp_valid_in) begin
                fault_cond_q <= below_fault;
                ut_warn_out <= below_warn;
                ot_warn_out <= above_warn;
            end
        end
    end

    // sticky status; a new fault wins over a clear in the same cycle
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ut_fault_out <= 1'b0;
        end else if (fault_new) begin
            ut_fault_out <= 1'b1;
        end else if (clr_evt) begin
            ut_fault_out <= 1'b0;
        end
    end

    tlf_pkg::tlf_state_t st_q;
    tlf_pkg::tlf_state_t st_d;
    logic [31:0] tmr_q;
    logic [31:0] tmr_d;
    logic [2:0] left_q;
    logic [2:0] left_d;

    // interval in cycles: delay units times the unit length
    wire logic [31:0] interval_cyc = 32'(UNIT_CYCLES) * {24'h000000, unit_mult(resp_q.delay)};
    wire logic [31:0] tmr_load = interval_cyc - 32'h00000001;
    wire logic expire = tmr_q == 32'h00000000;
    wire logic cont = resp_q.retries == `TLF_RETRY_CONT;
    wire logic no_retry = resp_q.retries == `TLF_RETRY_NONE;
    wire logic shut = fault_cond_q | fault_new;

    // response sequencer
    always_comb begin
        st_d = st_q;
        tmr_d = expire ? tmr_q : tmr_q - 32'h00000001;
        left_d = left_q;
        unique case (st_q)
            tlf_pkg::TLF_ST_RUN: begin
                if (fault_new) begin
                    unique case (resp_q.mode)
                        `TLF_MODE_IGNORE: st_d = tlf_pkg::TLF_ST_RUN;
                        `TLF_MODE_DELAY: begin
                            st_d = tlf_pkg::TLF_ST_DELAY;
                            tmr_d = tmr_load;
                        end
                        `TLF_MODE_RETRY: begin
                            st_d = no_retry ? tlf_pkg::TLF_ST_LATCHED : tlf_pkg::TLF_ST_WAIT;
                            tmr_d = tmr_load;
                            left_d = retry_limit(resp_q.retries);
                        end
                        `TLF_MODE_LATCH: st_d = tlf_pkg::TLF_ST_LATCHED;
                    endcase
                end
            end
            tlf_pkg::TLF_ST_DELAY: begin
                if (expire) begin
                    // fault gone at the end of the delay: carry on running
                    if (!shut) begin
                        st_d = tlf_pkg::TLF_ST_RUN;
                    end else begin
                        st_d = no_retry ? tlf_pkg::TLF_ST_LATCHED : tlf_pkg::TLF_ST_WAIT;
                        tmr_d = tmr_load;
                        left_d = retry_limit(resp_q.retries);
                    end
                end
            end
            tlf_pkg::TLF_ST_WAIT: begin
                // another fault shutting the unit down ends the retries too
                if (other_fault_in) begin
                    st_d = tlf_pkg::TLF_ST_LATCHED;
                end else if (expire) begin
                    if (!shut) begin
                        st_d = tlf_pkg::TLF_ST_RUN;
                    end else if (cont || left_q > 3'h1) begin
                        tmr_d = tmr_load;
                        left_d = cont ? left_q : left_q - 3'h1;
                    end else begin
                        st_d = tlf_pkg::TLF_ST_LATCHED;
                    end
                end
            end
            tlf_pkg::TLF_ST_LATCHED: st_d = tlf_pkg::TLF_ST_LATCHED;
            default: st_d = tlf_pkg::TLF_ST_LATCHED;
        endcase
        // any clearing action restarts supervision from running
        if (clr_evt) begin
            st_d = tlf_pkg::TLF_ST_RUN;
            tmr_d = 32'h00000000;
        end
    end

    wire logic out_on_d = run_cmd & (st_d == tlf_pkg::TLF_ST_RUN | st_d == tlf_pkg::TLF_ST_DELAY);

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= tlf_pkg::TLF_ST_RUN;
            tmr_q <= 32'h00000000;
            left_q <= 3'h0;
            output_en_out <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            left_q <= left_d;
            output_en_out <= out_on_d;
        end
    end
    assign state_out = st_q;

    chk_ignore_runs: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_RUN && fault_new && resp_q.mode == `TLF_MODE_IGNORE && run_cmd
        |=> st_q == tlf_pkg::TLF_ST_RUN && output_en_out)
        else $error("ignore mode left run state");

    chk_delay_keeps_on: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_RUN && fault_new && resp_q.mode == `TLF_MODE_DELAY && !clr_evt && run_cmd
        |=> st_q == tlf_pkg::TLF_ST_DELAY && output_en_out && tmr_q == $past(tmr_load))
        else $error("delay mode did not keep output on");

    chk_disable_at_once: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_RUN && fault_new && resp_q.mode == `TLF_MODE_RETRY && !clr_evt
        |=> !output_en_out && st_q != tlf_pkg::TLF_ST_RUN)
        else $error("retry mode did not disable output");

    chk_latch_holds: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_LATCHED && !clr_evt |=> st_q == tlf_pkg::TLF_ST_LATCHED && !output_en_out)
        else $error("latched fault released without clear");

    chk_clear_resumes: assert property (@(posedge clock_in) disable iff (!rst_n)
        clr_evt && !fault_new |=> st_q == tlf_pkg::TLF_ST_RUN && !ut_fault_out)
        else $error("clear did not restore run state");

    chk_no_retry_latch: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_RUN && fault_new && resp_q.mode == `TLF_MODE_RETRY && no_retry && !clr_evt
        |=> st_q == tlf_pkg::TLF_ST_LATCHED)
        else $error("zero retries did not latch off");

    chk_retry_count: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_WAIT && $past(st_q) != tlf_pkg::TLF_ST_WAIT
        |-> left_q == $past(resp_q.retries) && tmr_q == $past(tmr_load))
        else $error("retry count or interval wrong at start");

    chk_retries_spent: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_WAIT && expire && shut && !cont && left_q == 3'h1 && !clr_evt
        |=> st_q == tlf_pkg::TLF_ST_LATCHED ##1 !output_en_out)
        else $error("exhausted retries did not latch off");

    chk_retry_forever: assert property (@(posedge clock_in) disable iff (!rst_n)
        st_q == tlf_pkg::TLF_ST_WAIT && expire && shut && cont && !clr_evt && !other_fault_in
        |=> st_q == tlf_pkg::TLF_ST_WAIT && tmr_q == $past(tmr_load))
        else $error("continuous retry stopped");

    chk_fault_sticky: assert property (@(posedge clock_in) disable iff (!rst_n)
        fault_new |=> ut_fault_out && fault_cond_q)
        else $error("fault reading not flagged");

endmodule : tlf_fault_resp

//--- design/tlf_lin_cmp.sv
`timescale 1ns/1ns
`include "tlf_defs.svh"

// signed compare of two linear-format words
module tlf_lin_cmp (
    input wire tlf_pkg::tlf_lin_t a_in,
    input wire tlf_pkg::tlf_lin_t b_in,
    output wire logic a_lt_b_out
);

    // scale to one fixed point; 11-bit mantissa shifted up to 31 fits in 43 bits
    function automatic logic signed [42:0] to_fix(input tlf_pkg::tlf_lin_t v);
        logic signed [42:0] m;
        logic [4:0] sh;
        m = {{32{v.mant[10]}}, v.mant};
        sh = {~v.expo[4], v.expo[3:0]}; // exponent plus the bias
        return m <<< sh;
    endfunction : to_fix

    wire logic signed [42:0] a_fix = to_fix(a_in);
    wire logic signed [42:0] b_fix = to_fix(b_in);

    assign a_lt_b_out = a_fix < b_fix;

endmodule : tlf_lin_cmp

//--- design/tlf_pkg.sv
package tlf_pkg;

    // linear-format word: signed exponent over signed mantissa
    typedef struct packed {
        logic [4:0] expo;
        logic [10:0] mant;
    } tlf_lin_t;

    // fault response byte
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] retries;
        logic [2:0] delay;
    } tlf_resp_t;

    // supervision states, one-hot
    typedef enum logic [3:0] {
        TLF_ST_RUN = 4'h1,
        TLF_ST_DELAY = 4'h2,
        TLF_ST_WAIT = 4'h4,
        TLF_ST_LATCHED = 4'h8
    } tlf_state_t;

    // host command port
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] code;
        logic [15:0] wdata;
    } tlf_cmd_t;

endpackage : tlf_pkg

//--- test/temperature_limit_fault_response_test.sv
`timescale 1ns/1ns
`include "tlf_defs.svh"

module temperature_limit_fault_response_test;
    // short delay unit keeps the longest interval at 512 cycles
    localparam int UNIT = 4;
    localparam logic [15:0] WARM = 16'h0019;
    localparam logic [15:0] COLD = 16'h07CE;
    localparam logic [15:0] COOL = 16'h07DA;
    localparam logic [15:0] HOT = 16'h0082;
    localparam logic [7:0] CODES [5] = '{`TLF_CMD_OT_WARN, `TLF_CMD_UT_WARN, `TLF_CMD_UT_FAULT, `TLF_CMD_UT_RESP, 8'h60};
    localparam logic [15:0] RSTV [5] = '{`TLF_RST_OT_WARN, `TLF_RST_UT_WARN, `TLF_RST_UT_FAULT,
        {8'h00, `TLF_RST_UT_RESP}, 16'h0000};
    localparam logic [15:0] PATV [5] = '{16'hA5C3, 16'hA5C3, 16'hA5C3, 16'h00C3, 16'h0000};
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    tlf_pkg::tlf_cmd_t cmd_in;
    logic clear_faults_in = 1'b0;
    logic clear_status_in = 1'b0;
    logic op_on_in = 1'b1;
    logic ctrl_pin_in = 1'b1;
    logic bias_ok_in = 1'b1;
    tlf_pkg::tlf_lin_t temp_in = '0;
    logic temp_valid_in = 1'b0;
    logic other_fault_in = 1'b0;
    logic [15:0] rd_data_out;
    logic rd_valid_out, output_en_out, ut_fault_out, ut_warn_out, ot_warn_out;
    tlf_pkg::tlf_state_t state_out;
    int fail_count = 0;
    int checked = 0;

    tlf_fault_resp #(.UNIT_CYCLES(UNIT)) dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .cmd_in(cmd_in),
        .clear_faults_in(clear_faults_in), .clear_status_in(clear_status_in), .op_on_in(op_on_in),
        .ctrl_pin_in(ctrl_pin_in), .bias_ok_in(bias_ok_in), .temp_in(temp_in), .temp_valid_in(temp_valid_in),
        .other_fault_in(other_fault_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .output_en_out(output_en_out), .ut_fault_out(ut_fault_out), .ut_warn_out(ut_warn_out),
        .ot_warn_out(ot_warn_out), .state_out(state_out));

    tlf_host_model host (.clock_in(clock_in), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out),
        .cmd_out(cmd_in));

    // free-running 250 MHz clock
    always #2 clock_in = ~clock_in;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic expect_st(input tlf_pkg::tlf_state_t st, input logic en);
        chk("state_out", {12'h000, state_out}, {12'h000, st});
        chk("output_en_out", {15'h0000, output_en_out}, {15'h0000, en});
    endtask : expect_st

    // one qualified reading; returns just after the edge that took it
    task automatic reading(input logic [15:0] t);
        @(posedge clock_in);
        temp_in <= t;
        temp_valid_in <= 1'b1;
        @(posedge clock_in);
        temp_valid_in <= 1'b0;
        #1;
    endtask : reading

    task automatic set_resp(input logic [1:0] m, input logic [2:0] r, input logic [2:0] dl);
        host.write_reg(`TLF_CMD_UT_RESP, {8'h00, m, r, dl});
    endtask : set_resp

    // counts cycles spent in one state, bounded so a stuck state cannot hang the run
    task automatic dwell(input tlf_pkg::tlf_state_t st, output int n);
        n = 0;
        while (state_out === st && n < 2000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
    endtask : dwell

    // clearing actions: status bit, clear-faults, off-on by command, off-on by pin, bias loss
    task automatic do_clear(input int k);
        @(posedge clock_in);
        case (k)
            0: clear_status_in <= 1'b1;
            1: clear_faults_in <= 1'b1;
            2: op_on_in <= 1'b0;
            3: ctrl_pin_in <= 1'b0;
            default: bias_ok_in <= 1'b0;
        endcase
        repeat (k < 2 ? 1 : 6) @(posedge clock_in);
        clear_status_in <= 1'b0;
        clear_faults_in <= 1'b0;
        op_on_in <= 1'b1;
        ctrl_pin_in <= 1'b1;
        bias_ok_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        #1;
    endtask : do_clear

    task automatic recover();
        do_clear(1);
        reading(WARM);
    endtask : recover

    // main sequence
    initial begin
        logic [15:0] d;
        logic v;
        int n;
        repeat (2) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        for (int i = 0; i < 5; i++) begin
            host.read_reg(CODES[i], d, v);
            chk("read valid", {15'h0000, v}, 16'h0001);
            chk("reset value", d, RSTV[i]);
        end
        for (int i = 0; i < 5; i++) host.write_reg(CODES[i], 16'hA5C3);
        for (int i = 0; i < 5; i++) begin
            host.read_reg(CODES[i], d, v);
            chk("readback", d, PATV[i]);
        end
        for (int i = 0; i < 4; i++) host.write_reg(CODES[i], RSTV[i]);
        // fault limit -40 as exponent -1, mantissa -80
        host.write_reg(`TLF_CMD_UT_FAULT, 16'hFFB0);
        set_resp(2'h0, 3'h0, 3'h0);
        reading(16'h07D9);
        chk("ut_fault at -39", {15'h0000, ut_fault_out}, 16'h0000);
        reading(16'h07D7);
        chk("ut_fault at -41", {15'h0000, ut_fault_out}, 16'h0001);
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        do_clear(0);
        chk("ut_fault cleared", {15'h0000, ut_fault_out}, 16'h0000);
        reading(COOL);
        chk("warn flags cool", {13'h0000, ut_fault_out, ut_warn_out, ot_warn_out}, 16'h0002);
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        reading(HOT);
        chk("warn flags hot", {13'h0000, ut_fault_out, ut_warn_out, ot_warn_out}, 16'h0001);
        reading(WARM);
        // latch mode against every clearing action
        set_resp(2'h3, 3'h0, 3'h0);
        for (int k = 0; k < 5; k++) begin
            reading(COLD);
            expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
            repeat (20) @(posedge clock_in);
            #1;
            expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
            do_clear(k);
            expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
            reading(WARM);
        end
        // failing restarts: interval count per retry code
        for (int r = 1; r < 7; r++) begin
            set_resp(2'h2, r[2:0], 3'h0);
            reading(COLD);
            expect_st(tlf_pkg::TLF_ST_WAIT, 1'b0);
            dwell(tlf_pkg::TLF_ST_WAIT, n);
            chk("cycles retrying", n[15:0], 16'(r * UNIT));
            expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
            recover();
        end
        set_resp(2'h2, 3'h0, 3'h0);
        reading(COLD);
        repeat (3 * UNIT) @(posedge clock_in);
        #1;
        expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
        recover();
        // interval length per delay code
        for (int dl = 0; dl < 8; dl++) begin
            set_resp(2'h2, 3'h1, dl[2:0]);
            reading(COLD);
            dwell(tlf_pkg::TLF_ST_WAIT, n);
            chk("interval cycles", n[15:0], 16'(UNIT << dl));
            recover();
        end
        // successful restart once the fault is gone
        set_resp(2'h2, 3'h3, 3'h1);
        reading(COLD);
        reading(WARM);
        dwell(tlf_pkg::TLF_ST_WAIT, n);
        chk("cycles to restart", n[15:0], 16'(2 * UNIT - 2));
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        recover();
        // keep running through the delay, then retry once and latch
        set_resp(2'h1, 3'h1, 3'h1);
        reading(COLD);
        expect_st(tlf_pkg::TLF_ST_DELAY, 1'b1);
        dwell(tlf_pkg::TLF_ST_DELAY, n);
        chk("delay cycles", n[15:0], 16'(2 * UNIT));
        expect_st(tlf_pkg::TLF_ST_WAIT, 1'b0);
        dwell(tlf_pkg::TLF_ST_WAIT, n);
        chk("retry after delay", n[15:0], 16'(2 * UNIT));
        expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
        recover();
        reading(COLD);
        reading(WARM);
        dwell(tlf_pkg::TLF_ST_DELAY, n);
        chk("delay then run", n[15:0], 16'(2 * UNIT - 2));
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        recover();
        // endless retries while the fault stays, ended here by another fault
        set_resp(2'h2, 3'h7, 3'h0);
        reading(COLD);
        repeat (40 * UNIT) @(posedge clock_in);
        #1;
        expect_st(tlf_pkg::TLF_ST_WAIT, 1'b0);
        @(posedge clock_in);
        other_fault_in <= 1'b1;
        reading(WARM);
        repeat (4 * UNIT) @(posedge clock_in);
        #1;
        chk("output_en after other fault", {15'h0000, output_en_out}, 16'h0000);
        @(posedge clock_in);
        other_fault_in <= 1'b0;
        recover();
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        // reset in mid-run clears a latched fault, the flags and the response register
        set_resp(2'h3, 3'h0, 3'h0);
        reading(COLD);
        expect_st(tlf_pkg::TLF_ST_LATCHED, 1'b0);
        @(posedge clock_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (10) @(posedge clock_in);
        #1;
        expect_st(tlf_pkg::TLF_ST_RUN, 1'b1);
        chk("flags after reset", {13'h0000, ut_fault_out, ut_warn_out, ot_warn_out}, 16'h0000);
        host.read_reg(`TLF_CMD_UT_RESP, d, v);
        chk("resp after reset", d, {8'h00, `TLF_RST_UT_RESP});
        final_report();
    end

    // watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
endmodule : temperature_limit_fault_response_test

//--- test/tlf_host_model.sv
`timescale 1ns/1ns

// host side of the command port, one command per call
module tlf_host_model (
    input wire logic clock_in,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in,
    output tlf_pkg::tlf_cmd_t cmd_out
);
    initial begin
        cmd_out = '0;
    end

    // strobe held over one sampling edge; released fields are inverted so stale values never look valid
    task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(posedge clock_in);
        cmd_out <= '{wr_en: wr, rd_en: ~wr, code: code, wdata: data};
        @(posedge clock_in);
        cmd_out <= '{wr_en: 1'b0, rd_en: 1'b0, code: ~code, wdata: ~data};
    endtask : send

    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        send(1'b1, code, data);
    endtask : write_reg

    // answer settles just after the edge that took the read strobe
    task automatic read_reg(input logic [7:0] code, output logic [15:0] data, output logic valid);
        send(1'b0, code, 16'h0000);
        #1;
        valid = rd_valid_in;
        data = rd_data_in;
    endtask : read_reg
endmodule : tlf_host_model
